/* hdl/pll_clock_defines.vh */
`ifndef PLL_CLOCK_DEFINES_VH
`define PLL_CLOCK_DEFINES_VH

// Register address and layout.
`define PLL_CLOCK_CONTROL_ADDR  8'hd7
`define PLL_CLOCK_CONTROL_RESET 8'h03
`define OSC_SLEEP_HALT_BIT      7
`define LOCK_BIT                6
`define RESERVED_BIT            5
`define PIN_LATCH_BIT           4
`define FAST_INT_BIT            3
`define DIV_MSB                 2
`define DIV_LSB                 0

// Clock relations.
`define PLL_MULTIPLIER          384
`define XTAL_FREQ_HZ            32768
`define PLL_FREQ_HZ             12582912
`define FREE_RUN_TOLERANCE_PCT  20

// Timing at the 25 MHz reference clock.
`define REF_CLK_HZ              25000000
`define LOCK_TIME_US            1000
`define LOCK_CYCLES             ((`LOCK_TIME_US * (`REF_CLK_HZ / 1000)) / 1000)
`define XTAL_LOSS_CYCLES        2048

`endif

/* hdl/pll_core_clock_control.v */
`timescale 1ns/1ps
`include "pll_clock_defines.vh"

module pll_core_clock_control #(
  parameter LOCK_CYCLES      = `LOCK_CYCLES,
  parameter XTAL_LOSS_CYCLES = `XTAL_LOSS_CYCLES
) (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rst,
  // Register access
  input  wire [7:0] sfr_addr,
  input  wire       sfr_wr,
  input  wire [7:0] sfr_wdata,
  output reg  [7:0] sfr_rdata,
  // Clocks from the oscillator and loop
  input  wire       xtal_clk,
  input  wire       pll_clk,
  // Core power and interrupt status
  input  wire       power_down,
  input  wire       int_active,
  // Clock enables, oscillator and loop enables, lock flag
  output reg        core_clk_en,
  output reg        modulator_clk_en,
  output reg        osc_enable,
  output reg        pll_enable,
  output reg        lock_out
);

  // Lock sequencer states. Reset starts in relock, so the flag stays clear
  // until the crystal has counted as present for the whole lock interval.
  // Sleep is left only when the core leaves power-down.
  localparam ST_RUN   = 2'h0;
  localparam ST_SLEEP = 2'h1;
  localparam ST_RELOCK = 2'h2;

  reg [7:0]  ctrl_q;
  reg [1:0]  st_q;
  reg [2:0]  xs_q;
  reg [2:0]  ps_q;
  reg [8:0]  xtal_div_q;
  reg [6:0]  core_cnt_q;
  reg [2:0]  div_act_q;
  reg [31:0] lock_cnt_q;
  reg [31:0] loss_cnt_q;
  reg        lock_q;

  // The crystal is far slower than the reference; the loop clock at the defined rate is about half of it and can lose edges.
  // A loop clock near the reference rate would need a real divider instead.
  wire xtal_rise = xs_q[1] & ~xs_q[2];
  wire pll_rise  = ps_q[1] & ~ps_q[2];
  wire [2:0] div_req = (ctrl_q[`FAST_INT_BIT] & int_active) ? 3'h0 : ctrl_q[`DIV_MSB:`DIV_LSB];
  wire [6:0] div_mask = (7'h01 << div_act_q) - 7'h01;
  wire core_tick = pll_rise & ((core_cnt_q & div_mask) == 7'h00);
  // The crystal counts as present while edges keep arriving within the loss span.
  wire xtal_ok   = loss_cnt_q < XTAL_LOSS_CYCLES;

  // Two-stage synchronisers; the third stage only feeds edge detection.
  always @(posedge ref_clk) begin
    if (rst) begin
      xs_q <= 3'h0;
      ps_q <= 3'h0;
    end else begin
      xs_q <= {xs_q[1:0], xtal_clk};
      ps_q <= {ps_q[1:0], pll_clk};
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= `PLL_CLOCK_CONTROL_RESET;
    end else if (sfr_wr && sfr_addr == `PLL_CLOCK_CONTROL_ADDR) begin
      // Masking here keeps a careless write from ever faking a lock.
      // Bit 4 is kept as a plain storage bit.
      // Lock and reserved bits are not writable.
      ctrl_q <= {sfr_wdata[7], 2'b00, sfr_wdata[4:0]};
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_addr == `PLL_CLOCK_CONTROL_ADDR) begin
      // Read data is registered, so it shows one cycle after the address.
      // The lock bit comes from the live flag, not from the stored byte.
      sfr_rdata <= {ctrl_q[7], lock_q, 1'b0, ctrl_q[4:0]};
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // Divider applies a new setting only when the 128-edge core count wraps, so no short pulse.
  always @(posedge ref_clk) begin
    if (rst) begin
      core_cnt_q  <= 7'h00;
      div_act_q   <= 3'h3;
      core_clk_en <= 1'b0;
    end else begin
      core_clk_en <= core_tick;
      if (pll_rise) begin
        core_cnt_q <= core_cnt_q + 7'h01;
      end
      if (pll_rise && core_cnt_q == 7'h7f) begin
        div_act_q <= div_req;
      end
    end
  end

  // Modulator tick every 384 PLL clocks equals the crystal rate.
  always @(posedge ref_clk) begin
    if (rst) begin
      xtal_div_q       <= 9'h000;
      modulator_clk_en <= 1'b0;
    end else begin
      modulator_clk_en <= 1'b0;
      if (pll_rise) begin
        // Ticking on count zero puts every tick on a core edge at any divider,
        // because 384 is a multiple of the 128-edge divider wrap.
        modulator_clk_en <= (xtal_div_q == 9'h000);
        if (xtal_div_q == 9'd383) begin
          xtal_div_q <= 9'h000;
        end else begin
          xtal_div_q <= xtal_div_q + 9'h001;
        end
      end
    end
  end

  // Crystal presence watchdog; no edges means free-running loop without lock.
  // The count saturates at the loss span, so a long absence cannot wrap it.
  // While the oscillator is halted in sleep the count runs out; that is harmless
  // because sleep ignores it and relock starts again after wake.
  always @(posedge ref_clk) begin
    if (rst) begin
      loss_cnt_q <= 32'h0;
    end else if (xtal_rise) begin
      loss_cnt_q <= 32'h0;
    end else if (xtal_ok) begin
      loss_cnt_q <= loss_cnt_q + 32'h1;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      st_q       <= ST_RELOCK;
      lock_cnt_q <= 32'h0;
      lock_q     <= 1'b0;
      osc_enable <= 1'b1;
      pll_enable <= 1'b1;
      lock_out   <= 1'b0;
    end else begin
      lock_out <= lock_q;
      // Power-down is honoured in relock as well, so the loop never stays
      // enabled while the core sleeps.
      case (st_q)
        ST_RUN: begin
          if (!xtal_ok) begin
            lock_q <= 1'b0;
            st_q   <= ST_RELOCK;
          end else if (power_down) begin
            lock_q     <= 1'b0;
            pll_enable <= 1'b0;
            osc_enable <= ~ctrl_q[`OSC_SLEEP_HALT_BIT];
            st_q       <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          // The lock count restarts from zero, so the flag holds low after wake.
          if (!power_down) begin
            pll_enable <= 1'b1;
            osc_enable <= 1'b1;
            lock_cnt_q <= 32'h0;
            st_q       <= ST_RELOCK;
          end
        end
        ST_RELOCK: begin
          lock_q <= 1'b0;
          if (power_down) begin
            pll_enable <= 1'b0;
            osc_enable <= ~ctrl_q[`OSC_SLEEP_HALT_BIT];
            st_q       <= ST_SLEEP;
          end else if (!xtal_ok) begin
            lock_cnt_q <= 32'h0;
          end else if (lock_cnt_q >= LOCK_CYCLES - 1) begin
            lock_q <= 1'b1;
            st_q   <= ST_RUN;
          end else begin
            lock_cnt_q <= lock_cnt_q + 32'h1;
          end
        end
        default: begin
          st_q <= ST_RELOCK;
        end
      endcase
    end
  end

endmodule

/* dv/xtal_source.sv */
`timescale 1ns/1ps
module xtal_source #(parameter real HALF_NS = 60.0) (
  // Enables from the block
  input  wire logic osc_enable,
  input  wire logic pll_enable,
  // Crystal removal from the bench
  input  wire logic xtal_cut,
  // Clocks to the block
  output logic      xtal_clk,
  output logic      pll_clk
);
  // The loop clock is slowed so that 25 MHz sampling still sees every phase.
  // The crystal counts half periods on its own, so it keeps running while the loop sleeps.
  int n = 0;
  initial begin
    xtal_clk = 1'h0;
    pll_clk = 1'h0;
    forever begin
      #HALF_NS pll_clk = (pll_enable === 1'h1) && (pll_clk !== 1'h1);
      n = (n + 1) % 384;
      if (n == 0 && osc_enable === 1'h1 && xtal_cut !== 1'h1) xtal_clk = ~xtal_clk;
    end
  end
endmodule

/* dv/pll_core_clock_control_monitor.sv */
`timescale 1ns/1ps
module pll_core_clock_control_monitor (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       power_down,
  input wire logic       core_clk_en,
  input wire logic       modulator_clk_en,
  input wire logic       osc_enable,
  input wire logic       pll_enable,
  input wire logic       lock_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_reset_state: assert property (disable iff (1'h0) rst |=> !lock_out && osc_enable && pll_enable)
    else $error("reset state");
  a_lock_readback: assert property ($past(sfr_addr) == 8'hd7 |-> sfr_rdata[6:5] == {lock_out, 1'h0})
    else $error("lock readback");
  a_unmapped_zero: assert property ($past(sfr_addr) != 8'hd7 |-> sfr_rdata == 8'h00)
    else $error("unmapped read");
  a_write_stored: assert property (sfr_wr && sfr_addr == 8'hd7 ##1 sfr_addr == 8'hd7
    |=> (sfr_rdata & 8'h9f) == ($past(sfr_wdata, 2) & 8'h9f)) else $error("write lost");
  a_awake_enables: assert property (!power_down |=> osc_enable && pll_enable) else $error("awake enables");
  a_sleep_unlock: assert property (power_down |=> !pll_enable ##1 !lock_out) else $error("sleep lock");
  a_relock_hold: assert property ($fell(power_down) |-> !lock_out [*8]) else $error("early lock");
  a_core_pulse: assert property (core_clk_en |=> !core_clk_en) else $error("core pulse");
  a_modulator_sync: assert property (modulator_clk_en |-> core_clk_en ##1 !modulator_clk_en [*8])
    else $error("modulator sync");
  c_lock: cover property ($rose(lock_out));
  c_wake: cover property (power_down ##1 !power_down);
  c_mod: cover property (modulator_clk_en);
endmodule
bind pll_core_clock_control pll_core_clock_control_monitor i_monitor (.*);

/* dv/pll_core_clock_control_bench.sv */
`timescale 1ns/1ps
module pll_core_clock_control_bench;
  logic       ref_clk = 1'h0;
  logic       rst = 1'h1;
  logic [7:0] sfr_addr = 8'hd7;
  logic       sfr_wr = 1'h0;
  logic [7:0] sfr_wdata = 8'h00;
  logic       power_down = 1'h0;
  logic       int_active = 1'h0;
  logic       xtal_cut = 1'h0;
  logic [7:0] sfr_rdata;
  logic       xtal_clk, pll_clk, core_clk_en, modulator_clk_en, osc_enable, pll_enable, lock_out;
  int         n_errors = 0;
  int         checks_done = 0;
  int         n;
  // Each row: value written, value read back, core pulses per 384 loop edges.
  logic [31:0] rows [8] = '{32'h40400180, 32'h91d100c0, 32'h12520060, 32'h13530030,
                            32'h84c40018, 32'h1555000c, 32'h86c60006, 32'h07470003};
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  xtal_source i_xtal (.*);
  pll_core_clock_control #(.LOCK_CYCLES(20)) i_dut (.*);
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] v);
    @(posedge ref_clk) #1 sfr_wr = 1'h1;
    sfr_wdata = v;
    @(posedge ref_clk) #1 sfr_wr = 1'h0;
    @(posedge ref_clk) #1;
  endtask
  task automatic cnt(output int k);
    k = 0;
    while (!modulator_clk_en) @(posedge ref_clk) #1;
    do begin
      @(posedge ref_clk) #1 k += core_clk_en;
    end while (!modulator_clk_en);
  endtask
  task automatic print_verdict;
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    #1 rst = 1'h0;
    @(posedge ref_clk) #1 chk("reset value", 8'h03, sfr_rdata);
    wait (lock_out === 1'h1);
    foreach (rows[i]) begin
      wr(rows[i][31:24]);
      chk("readback", rows[i][23:16], sfr_rdata);
      cnt(n);
      cnt(n);
      cnt(n);
      chk("core pulses", rows[i][15:0], n[15:0]);
    end
    // A write elsewhere must leave the control value alone.
    sfr_addr = 8'hd6;
    wr(8'h00);
    chk("unmapped", 8'h00, sfr_rdata);
    sfr_addr = 8'hd7;
    @(posedge ref_clk) #1 chk("kept", 8'h47, sfr_rdata);
    wr(8'h0f);
    int_active = 1'h1;
    cnt(n);
    cnt(n);
    cnt(n);
    chk("fast pulses", 16'h0180, n[15:0]);
    int_active = 1'h0;
    wr(8'h87);
    power_down = 1'h1;
    repeat (2) @(posedge ref_clk) #1;
    chk("osc halt", 1'h0, osc_enable);
    power_down = 1'h0;
    @(posedge ref_clk) #1 chk("lock after wake", 1'h0, sfr_rdata[6]);
    wait (lock_out === 1'h1);
    @(posedge ref_clk) #1 chk("relock", 1'h1, sfr_rdata[6]);
    // Crystal removed while running: lock clears, the loop keeps running.
    xtal_cut = 1'h1;
    repeat (2200) @(posedge ref_clk);
    #1 chk("lock on loss", 1'h0, sfr_rdata[6]);
    chk("free run", 1'h1, pll_enable);
    xtal_cut = 1'h0;
    wait (lock_out === 1'h1);
    @(posedge ref_clk) #1 chk("lock regained", 1'h1, sfr_rdata[6]);
    print_verdict;
  end
  initial begin
    #3ms n_errors++;
    print_verdict;
  end
endmodule
